/* rswc_consts.svh */
// Constants of the reset, standby and watchdog controller: offsets, fields, reset values and timing.
// Assumes a 40 MHz system clock; the RC oscillator is modelled as a tick derived from it.
`ifndef RSWC_CONSTS_SVH
`define RSWC_CONSTS_SVH

`define ADDR_STOP_RECOVERY   8'h0B
`define ADDR_STATUS          8'h0C
`define ADDR_WATCHDOG_MODE   8'h0F

`define STOPREC_DIV16_BIT    0
`define STOPREC_DELAY_BIT    5
`define WDM_SEL_HI           1
`define WDM_SEL_LO           0
`define WDM_RUN_IN_HALT      2
`define STATUS_WDT_FLAG      7
`define STATUS_POR_BUSY      6
`define STATUS_SHORT_BUSY    5

`define STOPREC_RESET        8'h20
`define WDM_RESET            8'h04
`define RESTART_ADDR         16'h000C
`define ZERO_ADDR            16'h0000

`define CLK_PERIOD_NS        25
`define RC_TICK_NS           1000
`define RC_DIV               (`RC_TICK_NS / `CLK_PERIOD_NS)
`define PRESCALE_DIV         16
`define SHORT_RESET_CLOCKS   18

`define POR_TIME_US          2500
`define WDT_TIME0_MS         5
`define WDT_TIME1_MS         10
`define WDT_TIME2_MS         20
`define WDT_TIME3_MS         80
`define US_TO_TICKS(t)       (((t) * 1000 + `RC_TICK_NS - 1) / `RC_TICK_NS)
`define MS_TO_TICKS(t)       (((t) * 1000000 + `RC_TICK_NS - 1) / `RC_TICK_NS)

`endif

/* rswc_pkg.sv */
// Types shared by the reset, standby and watchdog controller.
// Holds only type declarations; constants live in the header.
package rswc_pkg;

	typedef enum logic [2:0] {
		ST_BROWN,
		ST_POR,
		ST_SHORT,
		ST_RUN,
		ST_HALT,
		ST_STOP
	} power_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic        coreResetN;
		logic        coreClkEn;
		logic        timerClkEn;
		logic        oscEnable;
		logic [15:0] restartAddr;
	} core_ctrl_t;

endpackage

/* tick_divider.sv */
// Free-running divider giving a one-cycle enable pulse every DIV clocks.
// Assumes DIV is at least 2.
`timescale 1ns/1ps
module tick_divider #(
	parameter int unsigned DIV = 16
) (
	// Clock and reset
	input  logic sys_clk,
	input  logic rst_n,
	// Enable pulse
	output logic tick
);
	localparam int unsigned W = $clog2(DIV);

	logic [W-1:0] cnt;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cnt  <= '0;
			tick <= 1'b0;
		end else if (cnt == W'(DIV - 1)) begin
			cnt  <= '0;
			tick <= 1'b1;
		end else begin
			cnt  <= cnt + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule

/* delay_one_shot.sv */
// One-shot delay timer started by a low-to-high step on its clear input.
// Counts COUNT+1 ticks so a partial first tick never shortens the delay.
`timescale 1ns/1ps
module delay_one_shot #(
	parameter int unsigned COUNT = 2500
) (
	// Clock and reset
	input  logic sys_clk,
	input  logic rst_n,
	// Time base and start
	input  logic tick,
	input  logic clearIn,
	// Status
	output logic busy,
	output logic done
);
	logic [16:0] cnt;
	logic        clearPrev;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			clearPrev <= 1'b0;
		end else begin
			clearPrev <= clearIn;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cnt  <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else if (clearIn && !clearPrev) begin
			cnt  <= 17'(COUNT);
			busy <= 1'b1;
			done <= 1'b0;
		end else if (busy && tick) begin
			if (cnt == '0) begin
				busy <= 1'b0;
				done <= 1'b1;
			end else begin
				cnt  <= cnt - 1'b1;
				done <= 1'b0;
			end
		end else begin
			done <= 1'b0;
		end
	end
endmodule

/* reset_standby_watchdog_control.sv */
// Reset, HALT/STOP standby and watchdog control for a small 8-bit controller core.
// Assumes a 40 MHz clock, synchronous inputs and interrupt requests already gated by their enables.
//
// Operation
// - The power-on delay is timed by the RC oscillator tick and the core stays in reset until it ends.
// - The delay is a one-shot started by supply good, by stop recovery with bit 5 set, or by watchdog timeout.
// - The delay lasts at least 2.5 ms before the core may run.
// - Bit 5 of the stop recovery register decides whether stop recovery skips the delay.
// - HALT gates the core clock but keeps the oscillator, timers and all six interrupt lines running.
// - HALT ends when an enabled interrupt request arrives, after which the core continues in order, or when a reset source such as watchdog timeout fires.
// - STOP halts both the core clock and the oscillator.
// - STOP ends only through a reset source; stop recovery or external reset then restarts execution at address 000C, a supply failure at 0000.
// - Bit 0 of the stop recovery register selects divide-by-16 clocks and is cleared by stop recovery.
// - Watchdog mode bits 1:0 select a timeout of at least 5, 10, 20 or 80 ms.
// - Watchdog mode bit 2, set by default, keeps the watchdog counting during HALT.
// - The delay timer and the 18-clock reset timer start on a rising edge of their clear inputs.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "rswc_consts.svh"
module reset_standby_watchdog_control
	import rswc_pkg::*;
#(
	parameter int unsigned POR_TICKS  = `US_TO_TICKS(`POR_TIME_US),
	parameter int unsigned WDT_TICKS0 = `MS_TO_TICKS(`WDT_TIME0_MS),
	parameter int unsigned WDT_TICKS1 = `MS_TO_TICKS(`WDT_TIME1_MS),
	parameter int unsigned WDT_TICKS2 = `MS_TO_TICKS(`WDT_TIME2_MS),
	parameter int unsigned WDT_TICKS3 = `MS_TO_TICKS(`WDT_TIME3_MS)
) (
	// Clock and reset
	input  logic       sys_clk,
	input  logic       rst_n,
	// Register port
	input  reg_req_t   regReq,
	output logic [7:0] rdata,
	// Core requests
	input  logic       haltReq,
	input  logic       stopReq,
	input  logic       wdtRefresh,
	input  logic [5:0] irqPending,
	// Wake and reset sources
	input  logic       supplyGood,
	input  logic       stopRecover,
	input  logic       extReset,
	// Core control
	output core_ctrl_t ctrl
);
	localparam int unsigned SHORT_COUNT = `SHORT_RESET_CLOCKS - 1;

	power_state_t state;
	power_state_t next_state;
	logic [7:0]   stopRecovery;
	logic [7:0]   watchdogMode;
	logic         wdtFlag;
	logic [16:0]  wdtCnt;
	logic [16:0]  wdtLimit;
	logic         wdtRun;
	logic         wdtTimeout;
	logic         supplyPrev;
	logic         extPrev;
	logic         supplyRise;
	logic         extRise;
	logic         recoverWithDelay;
	logic         porClear;
	logic         shortClear;
	logic         porBusy;
	logic         porDone;
	logic         shortBusy;
	logic         rcTick;
	logic         divTick;
	logic         slowTick;
	logic         leaveStop;

	// The RC time base runs on its own, so a slowed core clock never stretches the reset delay.
	tick_divider #(
		.DIV (`RC_DIV)
	) u_rc_tick (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.tick    (rcTick)
	);

	tick_divider #(
		.DIV (`PRESCALE_DIV)
	) u_prescale (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.tick    (divTick)
	);

	delay_one_shot #(
		.COUNT (POR_TICKS)
	) u_por_timer (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.tick    (rcTick),
		.clearIn (porClear),
		.busy    (porBusy),
		.done    (porDone)
	);

	delay_one_shot #(
		.COUNT (SHORT_COUNT)
	) u_short_timer (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.tick    (1'b1),
		.clearIn (shortClear),
		.busy    (shortBusy),
		.done    ()
	);

	assign supplyRise       = supplyGood && !supplyPrev;
	assign extRise          = extReset && !extPrev;
	assign recoverWithDelay = (state == ST_STOP) && stopRecover && stopRecovery[`STOPREC_DELAY_BIT];
	assign slowTick         = stopRecovery[`STOPREC_DIV16_BIT] ? divTick : 1'b1;
	assign leaveStop        = (state == ST_STOP) && (next_state != ST_STOP) && (next_state != ST_BROWN);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			supplyPrev <= 1'b0;
			extPrev    <= 1'b0;
		end else begin
			supplyPrev <= supplyGood;
			extPrev    <= extReset;
		end
	end

	// Each trigger raises the clear input for one cycle; the timer starts on that rising edge.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			porClear   <= 1'b0;
			shortClear <= 1'b0;
		end else begin
			porClear   <= supplyRise || wdtTimeout || (recoverWithDelay && supplyGood);
			shortClear <= extRise && supplyGood;
		end
	end

	always_comb begin
		next_state = state;
		if (!supplyGood) begin
			next_state = ST_BROWN;
		end else if (supplyRise || wdtTimeout) begin
			next_state = ST_POR;
		end else if (extRise) begin
			next_state = ST_SHORT;
		end else begin
			case (state)
				ST_POR: begin
					if (porDone) begin
						next_state = ST_RUN;
					end
				end
				ST_SHORT: begin
					if (!shortBusy && !shortClear && !extReset) begin
						next_state = ST_RUN;
					end
				end
				ST_RUN: begin
					if (stopReq) begin
						next_state = ST_STOP;
					end else if (haltReq) begin
						next_state = ST_HALT;
					end
				end
				ST_HALT: begin
					if (|irqPending) begin
						next_state = ST_RUN;
					end
				end
				ST_STOP: begin
					if (stopRecover) begin
						next_state = stopRecovery[`STOPREC_DELAY_BIT] ? ST_POR : ST_RUN;
					end
				end
				default: begin
					next_state = state;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state <= ST_BROWN;
		end else begin
			state <= next_state;
		end
	end

	// The watchdog sleeps in STOP together with the oscillator it would otherwise wake.
	assign wdtRun = (state == ST_RUN) || ((state == ST_HALT) && watchdogMode[`WDM_RUN_IN_HALT]);

	always_comb begin
		case (watchdogMode[`WDM_SEL_HI:`WDM_SEL_LO])
			2'h0: wdtLimit = 17'(WDT_TICKS0);
			2'h1: wdtLimit = 17'(WDT_TICKS1);
			2'h2: wdtLimit = 17'(WDT_TICKS2);
			default: wdtLimit = 17'(WDT_TICKS3);
		endcase
	end

	assign wdtTimeout = wdtRun && rcTick && !wdtRefresh && (wdtCnt >= wdtLimit);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wdtCnt <= '0;
		end else if (wdtRefresh || wdtTimeout || !wdtRun) begin
			wdtCnt <= '0;
		end else if (rcTick) begin
			wdtCnt <= wdtCnt + 1'b1;
		end
	end

	// Stop recovery clears the divide select even when software writes in the same cycle.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			stopRecovery <= `STOPREC_RESET;
		end else begin
			if (regReq.wr && (regReq.addr == `ADDR_STOP_RECOVERY)) begin
				stopRecovery <= regReq.wdata;
			end
			if (leaveStop) begin
				stopRecovery[`STOPREC_DIV16_BIT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			watchdogMode <= `WDM_RESET;
		end else if (regReq.wr && (regReq.addr == `ADDR_WATCHDOG_MODE)) begin
			watchdogMode <= regReq.wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wdtFlag <= 1'b0;
		end else if (wdtTimeout) begin
			wdtFlag <= 1'b1;
		end else if (regReq.wr && (regReq.addr == `ADDR_STATUS) && regReq.wdata[`STATUS_WDT_FLAG]) begin
			wdtFlag <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (!regReq.rd) begin
			rdata <= 8'h00;
		end else if (regReq.addr == `ADDR_STOP_RECOVERY) begin
			rdata <= stopRecovery;
		end else if (regReq.addr == `ADDR_WATCHDOG_MODE) begin
			rdata <= watchdogMode;
		end else if (regReq.addr == `ADDR_STATUS) begin
			rdata <= {wdtFlag, porBusy, shortBusy, 2'h0, state};
		end else begin
			rdata <= 8'h00;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ctrl.coreResetN  <= 1'b0;
			ctrl.coreClkEn   <= 1'b0;
			ctrl.timerClkEn  <= 1'b0;
			ctrl.oscEnable   <= 1'b1;
			ctrl.restartAddr <= `ZERO_ADDR;
		end else begin
			ctrl.coreResetN  <= (state == ST_RUN) || (state == ST_HALT) || (state == ST_STOP);
			ctrl.coreClkEn   <= (state == ST_RUN) && slowTick;
			ctrl.timerClkEn  <= ((state == ST_RUN) || (state == ST_HALT)) && slowTick;
			ctrl.oscEnable   <= (state != ST_STOP);
			if (leaveStop) begin
				ctrl.restartAddr <= `RESTART_ADDR;
			end else if ((next_state == ST_BROWN) || wdtTimeout) begin
				ctrl.restartAddr <= `ZERO_ADDR;
			end
		end
	end

	// Helper counters for the timing checks below.
	logic [31:0] porCycles;
	logic [7:0]  shortCycles;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			porCycles   <= '0;
			shortCycles <= '0;
		end else begin
			porCycles   <= porBusy ? porCycles + 1'b1 : 32'h0000_0000;
			shortCycles <= shortBusy ? shortCycles + 1'b1 : 8'h00;
		end
	end

	sequence stopLeaveSeq;
		(state == ST_STOP) ##1 ((state != ST_STOP) && (state != ST_BROWN));
	endsequence

	sequence porStartSeq;
		porClear ##1 porBusy;
	endsequence

	chk_por_hold_core: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state == ST_POR) |=> !ctrl.coreResetN)
		else $error("Core left reset during the power-on delay.");

	chk_por_trigger: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(supplyRise || wdtTimeout) |=> porStartSeq)
		else $error("Power-on delay was not started by its trigger.");

	chk_por_min_time: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(porBusy) |-> (porCycles >= POR_TICKS * `RC_DIV))
		else $error("Power-on delay ended too early.");

	chk_recovery_bypass: assert property (@(posedge sys_clk) disable iff (!rst_n)
		((state == ST_STOP) && stopRecover && !stopRecovery[`STOPREC_DELAY_BIT] && supplyGood && supplyPrev
		&& !extRise) |=> (state == ST_RUN) && !porBusy)
		else $error("Stop recovery did not skip the delay.");

	chk_halt_clock: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state == ST_HALT) |=> !ctrl.coreClkEn && ctrl.oscEnable)
		else $error("HALT did not gate only the core clock.");

	chk_halt_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
		((state == ST_HALT) && !(|irqPending) && supplyGood && supplyPrev && !extRise && !wdtTimeout)
		|=> (state == ST_HALT))
		else $error("HALT ended without an interrupt.");

	chk_stop_osc: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state == ST_STOP) |=> !ctrl.oscEnable && !ctrl.coreClkEn)
		else $error("STOP left a clock running.");

	chk_stop_vector: assert property (@(posedge sys_clk) disable iff (!rst_n)
		stopLeaveSeq |-> (ctrl.restartAddr == `RESTART_ADDR))
		else $error("STOP exit did not restart at the recovery address.");

	chk_div_cleared: assert property (@(posedge sys_clk) disable iff (!rst_n)
		stopLeaveSeq |-> !stopRecovery[`STOPREC_DIV16_BIT])
		else $error("Divide select survived stop recovery.");

	chk_wdt_limit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wdtTimeout |-> (wdtCnt == wdtLimit) ##1 (state == ST_POR) && (wdtCnt == 17'h00000))
		else $error("Watchdog fired at the wrong count.");

	chk_halt_watchdog: assert property (@(posedge sys_clk) disable iff (!rst_n)
		((state == ST_HALT) && !watchdogMode[`WDM_RUN_IN_HALT]) |=> (wdtCnt == 17'h00000))
		else $error("Watchdog counted in HALT while disabled.");

	chk_short_length: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(shortBusy) |-> (shortCycles == 8'(`SHORT_RESET_CLOCKS)))
		else $error("Short reset timer did not last 18 clocks.");

	chk_short_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(extRise && supplyGood) |=> shortClear ##1 shortBusy)
		else $error("Short reset timer did not start on its clear edge.");

endmodule

/* core_model.sv */
// Core model: issues HALT and STOP requests on command and keeps the watchdog fed.
// Assumes the bench raises doHalt or doStop for one cycle while the core runs.
`timescale 1ns/1ps
module core_model (
	// Clock
	input  logic       sys_clk,
	// Bench commands
	input  logic       doHalt,
	input  logic       doStop,
	input  logic       feedOn,
	// Requests to the controller
	output logic       haltReq,
	output logic       stopReq,
	output logic       wdtRefresh,
	output logic [7:0] lastOp
);
	logic pendHalt = 1'b0;
	logic pendStop = 1'b0;
	int   feedCnt  = 0;
	initial begin
		haltReq = 1'b0;
		stopReq = 1'b0;
		wdtRefresh = 1'b0;
		lastOp = 8'h00;
	end
	// Feeding every 100 clocks stays inside the shortest timeout the bench selects.
	always @(posedge sys_clk) begin
		feedCnt <= (feedCnt == 99) ? 0 : feedCnt + 1;
		wdtRefresh <= feedOn && feedCnt == 0;
		haltReq <= pendHalt;
		stopReq <= pendStop;
		pendHalt <= doHalt;
		pendStop <= doStop;
		if (doHalt || doStop) begin
			lastOp <= 8'hFF;
		end else if (pendHalt || pendStop) begin
			lastOp <= 8'h00;
		end
	end
endmodule

/* reset_standby_watchdog_control_tb.sv */
// Bench for the reset, standby and watchdog controller with a core model on its far side.
// Assumes shortened timer parameters; one RC tick lasts RC_DIV clocks.
`timescale 1ns/1ps
`include "rswc_consts.svh"
module reset_standby_watchdog_control_tb
	import rswc_pkg::*;
;
	localparam int POR_T = 3;
	localparam int RC = `RC_DIV;
	logic       sys_clk;
	logic       rst_n;
	reg_req_t   regReq;
	logic [7:0] rdata;
	logic       haltReq;
	logic       stopReq;
	logic       wdtRefresh;
	logic [5:0] irqPending;
	logic       supplyGood;
	logic       stopRecover;
	logic       extReset;
	core_ctrl_t ctrl;
	logic       doHalt;
	logic       doStop;
	logic       feedOn;
	logic [7:0] rd;
	int         errorCnt;
	int         totalChecks;
	int         n;
	int         k;
	int         wdtLim[4] = '{4, 6, 8, 10};
	reset_standby_watchdog_control #(.POR_TICKS(POR_T), .WDT_TICKS0(4), .WDT_TICKS1(6),
		.WDT_TICKS2(8), .WDT_TICKS3(10)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .regReq(regReq),
		.rdata(rdata), .haltReq(haltReq), .stopReq(stopReq), .wdtRefresh(wdtRefresh),
		.irqPending(irqPending), .supplyGood(supplyGood), .stopRecover(stopRecover),
		.extReset(extReset), .ctrl(ctrl));
	core_model core (.sys_clk(sys_clk), .doHalt(doHalt), .doStop(doStop), .feedOn(feedOn),
		.haltReq(haltReq), .stopReq(stopReq), .wdtRefresh(wdtRefresh), .lastOp());
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic cmpVal(input logic [15:0] got, input logic [15:0] exp);
		totalChecks++;
		if (got !== exp) begin
			errorCnt++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmpSpan(input int got, input int lo, input int hi);
		totalChecks++;
		if (got < lo || got > hi) begin
			errorCnt++;
			$display("MISMATCH at %0t: span %h outside %h to %h", $time, got, lo, hi);
		end
	endtask
	task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		regReq.wr <= 1'b0;
	endtask
	// Read data stand for one cycle only, so they are taken just after the edge.
	task automatic regRead(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		regReq.rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic chkState(input logic [2:0] st);
		regRead(`ADDR_STATUS, rd);
		cmpVal({13'h0, rd[2:0]}, {13'h0, st});
	endtask
	task automatic waitReset(input logic lvl, output int c);
		c = 0;
		while (ctrl.coreResetN !== lvl && c < 20000) begin
			@(posedge sys_clk);
			#1;
			c++;
		end
	endtask
	task automatic issue(input logic stop);
		@(posedge sys_clk);
		doStop <= stop;
		doHalt <= !stop;
		@(posedge sys_clk);
		doStop <= 1'b0;
		doHalt <= 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
	endtask
	task automatic recover();
		@(posedge sys_clk);
		stopRecover <= 1'b1;
		@(posedge sys_clk);
		stopRecover <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	// Stops feeding right at a refresh, so the timeout is measured from a known clear.
	task automatic starve();
		@(posedge sys_clk);
		while (wdtRefresh !== 1'b1) @(posedge sys_clk);
		feedOn <= 1'b0;
	endtask
	task automatic stopTest();
		$display("Checks %0d, mismatches %0d", totalChecks, errorCnt);
		if (errorCnt == 0 && totalChecks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic testPowerOn();
		repeat (6) @(posedge sys_clk);
		regRead(`ADDR_STATUS, rd);
		cmpVal({8'h0, rd & 8'hE7}, 16'h0041);
		cmpVal({15'h0, ctrl.coreResetN}, 16'h0000);
		waitReset(1'b1, n);
		cmpSpan(n + 7, POR_T * RC, (POR_T + 2) * RC + 8);
	endtask
	task automatic testRegisters();
		logic [7:0] adr[3] = '{`ADDR_STOP_RECOVERY, `ADDR_WATCHDOG_MODE, 8'h10};
		logic [7:0] dflt[3] = '{`STOPREC_RESET, `WDM_RESET, 8'h00};
		regWrite(8'h10, 8'hFF);
		for (int i = 0; i < 3; i++) begin
			regRead(adr[i], rd);
			cmpVal({8'h0, rd}, {8'h0, dflt[i]});
			@(posedge sys_clk);
			#1;
			cmpVal({8'h0, rdata}, 16'h0000);
		end
		regWrite(`ADDR_WATCHDOG_MODE, 8'h07);
		regRead(`ADDR_WATCHDOG_MODE, rd);
		cmpVal({8'h0, rd}, 16'h0007);
		regWrite(`ADDR_WATCHDOG_MODE, `WDM_RESET);
	endtask
	// Each of the six interrupt lines must end HALT on its own.
	task automatic testHalt();
		for (int i = 0; i < 6; i++) begin
			issue(1'b0);
			chkState(3'd4);
			cmpVal({13'h0, ctrl.coreClkEn, ctrl.timerClkEn, ctrl.oscEnable}, 16'h0003);
			@(posedge sys_clk);
			irqPending <= 6'h01 << i;
			@(posedge sys_clk);
			irqPending <= 6'h00;
			repeat (2) @(posedge sys_clk);
			#1;
			cmpVal({14'h0, ctrl.coreClkEn, ctrl.coreResetN}, 16'h0003);
			chkState(3'd3);
		end
	endtask
	task automatic testStopFast();
		regWrite(`ADDR_STOP_RECOVERY, 8'h01);
		n = 0;
		k = 0;
		repeat (64) begin
			@(posedge sys_clk);
			#1;
			if (ctrl.coreClkEn === 1'b1) n++;
			if (ctrl.timerClkEn === 1'b1) k++;
		end
		cmpSpan(n, 4, 4);
		cmpSpan(k, 4, 4);
		issue(1'b1);
		cmpVal({14'h0, ctrl.oscEnable, ctrl.coreClkEn}, 16'h0000);
		@(posedge sys_clk);
		irqPending <= 6'h3F;
		repeat (300) @(posedge sys_clk);
		irqPending <= 6'h00;
		chkState(3'd5);
		recover();
		cmpVal({14'h0, ctrl.oscEnable, ctrl.coreResetN}, 16'h0003);
		cmpVal(ctrl.restartAddr, `RESTART_ADDR);
		regRead(`ADDR_STOP_RECOVERY, rd);
		cmpVal({8'h0, rd}, 16'h0000);
	endtask
	task automatic testStopSlow();
		regWrite(`ADDR_STOP_RECOVERY, `STOPREC_RESET);
		issue(1'b1);
		recover();
		chkState(3'd1);
		waitReset(1'b1, n);
		cmpSpan(n + 4, POR_T * RC, (POR_T + 2) * RC + 8);
		cmpVal(ctrl.restartAddr, `RESTART_ADDR);
	endtask
	task automatic testWatchdog();
		for (int m = 0; m < 4; m++) begin
			regWrite(`ADDR_WATCHDOG_MODE, 8'h04 | 8'(m));
			starve();
			waitReset(1'b0, n);
			cmpSpan(n, wdtLim[m] * RC, (wdtLim[m] + 2) * RC + 4);
			regRead(`ADDR_STATUS, rd);
			cmpVal({15'h0, rd[7]}, 16'h0001);
			cmpVal(ctrl.restartAddr, `ZERO_ADDR);
			@(posedge sys_clk);
			feedOn <= 1'b1;
			waitReset(1'b1, n);
			regWrite(`ADDR_STATUS, 8'h80);
		end
		regRead(`ADDR_STATUS, rd);
		cmpVal({15'h0, rd[7]}, 16'h0000);
	endtask
	task automatic testHaltWdt();
		regWrite(`ADDR_WATCHDOG_MODE, 8'h00);
		starve();
		issue(1'b0);
		repeat (400) @(posedge sys_clk);
		chkState(3'd4);
		@(posedge sys_clk);
		irqPending <= 6'h20;
		feedOn <= 1'b1;
		@(posedge sys_clk);
		irqPending <= 6'h00;
		regWrite(`ADDR_WATCHDOG_MODE, `WDM_RESET);
		starve();
		issue(1'b0);
		waitReset(1'b0, n);
		cmpSpan(n + 6, 4 * RC, 6 * RC + 4);
		@(posedge sys_clk);
		feedOn <= 1'b1;
		waitReset(1'b1, n);
		regWrite(`ADDR_STATUS, 8'h80);
	endtask
	task automatic testExtReset();
		@(posedge sys_clk);
		extReset <= 1'b1;
		repeat (3) @(posedge sys_clk);
		extReset <= 1'b0;
		regRead(`ADDR_STATUS, rd);
		cmpVal({8'h0, rd & 8'hE7}, 16'h0022);
		waitReset(1'b1, n);
		cmpSpan(n + 4, `SHORT_RESET_CLOCKS, `SHORT_RESET_CLOCKS + 8);
	endtask
	task automatic testBrownout();
		@(posedge sys_clk);
		supplyGood <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chkState(3'd0);
		cmpVal({15'h0, ctrl.coreResetN}, 16'h0000);
		@(posedge sys_clk);
		supplyGood <= 1'b1;
		waitReset(1'b1, n);
		cmpSpan(n, POR_T * RC, (POR_T + 2) * RC + 4);
	endtask
	initial begin
		#(30000 * `CLK_PERIOD_NS);
		errorCnt++;
		$display("Timeout at %0t", $time);
		stopTest();
	end
	initial begin
		rst_n = 1'b0;
		regReq = '0;
		irqPending = 6'h00;
		supplyGood = 1'b1;
		stopRecover = 1'b0;
		extReset = 1'b0;
		doHalt = 1'b0;
		doStop = 1'b0;
		feedOn = 1'b1;
		errorCnt = 0;
		totalChecks = 0;
		repeat (10) @(posedge sys_clk);
		#1;
		cmpVal({14'h0, ctrl.coreResetN, ctrl.oscEnable}, 16'h0001);
		@(posedge sys_clk);
		rst_n <= 1'b1;
		testPowerOn();
		testRegisters();
		testHalt();
		testStopFast();
		testStopSlow();
		testWatchdog();
		testHaltWdt();
		testExtReset();
		testBrownout();
		stopTest();
	end
endmodule
